//--- dscd_top.sv
/*
  Serial command decoder for a sixteen-channel DAC in two groups of eight.
  Assumes every pin is asynchronous to core_clk and far slower than it,
  so each serial clock level lasts several core cycles.
*/
`timescale 1ns/10ps
module dscd_top
  import dscd_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     serialShiftClock,
  input  wire logic                     serialDataIn,
  input  wire logic                     frameSelectLowGroup_b,
  input  wire logic                     frameSelectHighGroup_b,
  input  wire logic                     loadOutputsInput_b,
  input  wire logic                     asyncClearInput_b,
  output logic      [NUM_CH*DATA_W-1:0] dacCodeOut,
  output logic      [NUM_CH*2-1:0]      powerModeOut,
  output logic                          internalReferenceEnable_q,
  output logic                          refPowerOn_q,
  output logic                          clearState_q
);
  logic [SYNC_W-1:0]     pinSync;
  logic                  sclkPrev_q;
  logic                  clrPrev_q;
  dscd_frame_e           frState_q;
  logic [BIT_CNT_W-1:0]  bitCnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [NUM_GRP-1:0]    groupSel_q;
  logic                  execPulse_q;
  logic [1:0]            clearCodeSelect_q;
  logic [POR_CNT_W-1:0]  porCnt_q;
  logic [NUM_CH-1:0]     chanDown;

  dscd_sync #(
    .W    (SYNC_W),
    .IDLE (SYNC_IDLE)
  ) u_sync (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .pinIn     ({serialShiftClock, serialDataIn, frameSelectLowGroup_b,
                 frameSelectHighGroup_b, loadOutputsInput_b, asyncClearInput_b}),
    .syncOut_q (pinSync)
  );

  wire sclkS     = pinSync[5];
  wire dinS      = pinSync[4];
  wire selLowS_b = pinSync[3];
  wire selHiS_b  = pinSync[2];
  wire loadS_b   = pinSync[1];
  wire clrS_b    = pinSync[0];

  wire porBusy   = porCnt_q != '0;
  wire anySelLow = !selLowS_b || !selHiS_b;
  wire sclkFall  = sclkPrev_q && !sclkS;
  wire clearFall = clrPrev_q && !clrS_b;
  // Clear and load pins load no codes until the power-on hold expires; a clear fall still aborts a frame
  wire clearSeen = clearFall && !porBusy;
  wire loadLow   = !loadS_b && !porBusy;
  wire lastEdge  = (frState_q == FR_SHIFT) && anySelLow && !clearFall && sclkFall
                   && (bitCnt_q == LAST_BIT);

  // Decoded fields of the completed frame
  wire [CMD_W-1:0]  cmdField  = shift_q[CMD_LO +: CMD_W];
  wire [ADDR_W-1:0] addrField = shift_q[ADDR_LO +: ADDR_W];
  wire [DATA_W-1:0] codeField = shift_q[CODE_LO +: DATA_W];
  wire [1:0]        pdField   = shift_q[PD_LO +: 2];
  wire [1:0]        clrsField = shift_q[CLRS_LO +: 2];

  wire isWriteIn  = cmdField == CMD_WRITE_IN;
  wire isUpdate   = cmdField == CMD_UPDATE;
  wire isWriteAll = cmdField == CMD_WRITE_ALL;
  wire isWriteUpd = cmdField == CMD_WRITE_UPD;
  // Reserved codes match nothing below; they only end the clear state
  wire doPower    = execPulse_q && (cmdField == CMD_POWER);
  wire doClearSel = execPulse_q && (cmdField == CMD_CLEAR_SEL);
  wire doSwReset  = execPulse_q && (cmdField == CMD_SW_RESET);
  wire doRefSetup = execPulse_q && (cmdField == CMD_REF_SETUP);

  wire clearEnable = clearCodeSelect_q != CLR_SEL_NOP;
  wire [DATA_W-1:0] clearCodeVal =
    (clearCodeSelect_q == CLR_SEL_MID)  ? CLR_CODE_MID  :
    (clearCodeSelect_q == CLR_SEL_FULL) ? CLR_CODE_FULL : CLR_CODE_ZERO;
  wire clearLoad = clearSeen && clearEnable;

  wire allDown = &chanDown;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sclkPrev_q <= 1'b1;
      clrPrev_q  <= 1'b1;
    end
    else
    begin
      sclkPrev_q <= sclkS;
      clrPrev_q  <= clrS_b;
    end
  end

  // Power-on hold, restarted by the software reset command
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || doSwReset)
      porCnt_q <= POR_CNT_W'(POR_CYCLES);
    else if (porBusy)
      porCnt_q <= porCnt_q - 1'b1;
  end

  // Frame sequencer; both groups share one shift register
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      frState_q   <= FR_IDLE;
      bitCnt_q    <= '0;
      shift_q     <= '0;
      groupSel_q  <= '0;
      execPulse_q <= 1'b0;
    end
    else
    begin
      execPulse_q <= lastEdge;
      case (frState_q)
        FR_IDLE:
        begin
          if (anySelLow)
          begin
            frState_q <= FR_SHIFT;
            bitCnt_q  <= '0;
            shift_q   <= '0;
          end
        end
        FR_SHIFT:
        begin
          if (!anySelLow)
          begin
            frState_q <= FR_IDLE;
            shift_q   <= '0;
            bitCnt_q  <= '0;
          end
          else if (clearFall)
          begin
            frState_q <= FR_WAIT;
            shift_q   <= '0;
            bitCnt_q  <= '0;
          end
          else if (sclkFall)
          begin
            shift_q  <= {shift_q[FRAME_BITS-2:0], dinS};
            bitCnt_q <= bitCnt_q + 1'b1;
            if (bitCnt_q == LAST_BIT)
            begin
              frState_q  <= FR_WAIT;
              groupSel_q <= {!selHiS_b, !selLowS_b};
            end
          end
        end
        FR_WAIT:
        begin
          // Further edges are ignored until the frame select goes high
          if (!anySelLow)
          begin
            frState_q <= FR_IDLE;
            bitCnt_q  <= '0;
          end
        end
        default:
        begin
          frState_q <= FR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b || doSwReset)
    begin
      internalReferenceEnable_q <= REF_RESET;
      clearCodeSelect_q         <= CLR_SEL_ZERO;
    end
    else
    begin
      if (doRefSetup)
        internalReferenceEnable_q <= shift_q[REF_BIT];
      if (doClearSel)
        clearCodeSelect_q <= clrsField;
    end
  end

  // Set wins over the exit when both land together
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || doSwReset)
      clearState_q <= 1'b0;
    else if (clearLoad)
      clearState_q <= 1'b1;
    else if (execPulse_q)
      clearState_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      refPowerOn_q <= 1'b0;
    else
      refPowerOn_q <= internalReferenceEnable_q && !allDown;
  end

  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_chan
    localparam int GRP = ch / CH_PER_GRP;
    localparam int IDX = ch % CH_PER_GRP;

    wire grpHit  = execPulse_q && groupSel_q[GRP];
    wire chanHit = grpHit && ((addrField == ADDR_W'(IDX)) || (addrField == ADDR_ALL));
    wire wrIn    = chanHit && (isWriteIn || isWriteAll || isWriteUpd);
    wire upd     = (chanHit && (isUpdate || isWriteUpd)) || (grpHit && isWriteAll);
    wire modeWr  = doPower && groupSel_q[GRP] && shift_q[CHSEL_LO + IDX];

    logic [DATA_W-1:0] dacCode_q_w;
    logic [1:0]        powerMode_q_w;

    dscd_channel u_chan (
      .core_clk    (core_clk),
      .rst_b       (rst_b),
      .swReset     (doSwReset),
      .writeInput  (wrIn),
      .updateDac   (upd),
      .newCode     (codeField),
      .clearLoad   (clearLoad),
      .clearCode   (clearCodeVal),
      .loadLow     (loadLow),
      .modeWrite   (modeWr),
      .modeVal     (pdField),
      .dacCode_q   (dacCode_q_w),
      .powerMode_q (powerMode_q_w)
    );

    assign dacCodeOut[ch*DATA_W +: DATA_W] = dacCode_q_w;
    assign powerModeOut[ch*2 +: 2]          = powerMode_q_w;
    assign chanDown[ch]                     = powerMode_q_w != PD_NORMAL;
  end

  a_exec_at_last : assert property (@(posedge core_clk) disable iff (!rst_b)
    (frState_q == FR_SHIFT) && anySelLow && !clearFall && sclkFall
    && (bitCnt_q == LAST_BIT) |=> execPulse_q ##1 !execPulse_q)
    else $error("Frame not executed on its last falling edge");

  a_exec_needs_count : assert property (@(posedge core_clk) disable iff (!rst_b)
    execPulse_q |-> $past(bitCnt_q) == LAST_BIT && frState_q == FR_WAIT)
    else $error("Execution without a full frame");

  a_early_abort : assert property (@(posedge core_clk) disable iff (!rst_b)
    (frState_q == FR_SHIFT) && !anySelLow |=> frState_q == FR_IDLE && shift_q == '0
    ##1 !execPulse_q)
    else $error("Short frame was not discarded");

  a_clear_abort : assert property (@(posedge core_clk) disable iff (!rst_b)
    (frState_q == FR_SHIFT) && anySelLow && clearFall |=> frState_q == FR_WAIT
    ##1 !execPulse_q)
    else $error("Write not aborted by clear");

  a_ref_setup : assert property (@(posedge core_clk) disable iff (!rst_b)
    doRefSetup |=> internalReferenceEnable_q == $past(shift_q[REF_BIT]))
    else $error("Reference register not written");

  a_soft_reset : assert property (@(posedge core_clk) disable iff (!rst_b)
    doSwReset |=> !internalReferenceEnable_q && clearCodeSelect_q == CLR_SEL_ZERO
    && porBusy && dacCodeOut == '0 && !clearState_q)
    else $error("Software reset incomplete");

  a_por_ignore : assert property (@(posedge core_clk) disable iff (!rst_b)
    porBusy && !clearState_q |=> !clearState_q)
    else $error("Clear acted during power-on hold");

  a_clear_exit : assert property (@(posedge core_clk) disable iff (!rst_b)
    execPulse_q && !clearLoad |=> !clearState_q)
    else $error("Clear state kept after valid frame");

  a_clear_full : assert property (@(posedge core_clk) disable iff (!rst_b)
    clearLoad && clearCodeSelect_q == CLR_SEL_FULL && !doSwReset
    |=> dacCodeOut[DATA_W-1:0] == CLR_CODE_FULL && clearState_q)
    else $error("Clear code not loaded");

  a_ref_all_down : assert property (@(posedge core_clk) disable iff (!rst_b)
    allDown |=> !refPowerOn_q)
    else $error("Reference on with every channel down");
endmodule : dscd_top

//--- dscd_pkg.sv
/*
  Constants, field layout, command codes and timing for the serial DAC command decoder.
  Assumes a 10 MHz core clock and 32-bit frames shifted most significant bit first.
*/
// Contract
// - Capture each frame in 32-bit shift register
// - Frame: 4 ignored, command, address, code, 8 ignored
// - Execute on 32nd falling serial clock edge
// - Commands 0..3 write, update, update-all, write-update
// - Address 0..7 picks channel, all ones picks eight
// - Early frame select rise clears and discards frame
// - Reference off at reset, command 1000 sets it
// - Outputs zero at reset; command 0111 resets all
// - Load and clear ignored during power-on reset; a clear fall still aborts a frame
// - Command 0100 sets power mode from DB9:DB8
// - Low eight bits pick channels to power mode
// - Reference off only all down; codes kept
// - Power-up takes input code if load low
// - Clear falling edge loads clear code everywhere
// - Command 0101 stores clear select, default zero
// - Clear state ends at next valid frame
// - Clear during frame aborts that write
// - Clear select 00/01/10 codes, 11 no clear
// - Data sampled on serial clock falling edge
// - Load low copies input registers to outputs
package dscd_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int POR_HOLD_NS   = 2000;
  localparam int POR_CYCLES    = (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CNT_W     = $clog2(POR_CYCLES + 1);

  localparam int FRAME_BITS = 32;
  localparam int BIT_CNT_W  = 6;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 6'h1F;
  localparam int NUM_CH     = 16;
  localparam int CH_PER_GRP = 8;
  localparam int NUM_GRP    = 2;
  localparam int DATA_W     = 12;
  localparam int CMD_W      = 4;
  localparam int ADDR_W     = 4;
  localparam int SYNC_W     = 6;

  localparam int CMD_LO   = 24;
  localparam int ADDR_LO  = 20;
  localparam int CODE_LO  = 8;
  localparam int PD_LO    = 8;
  localparam int CHSEL_LO = 0;
  localparam int REF_BIT  = 0;
  localparam int CLRS_LO  = 0;

  localparam logic [CMD_W-1:0] CMD_WRITE_IN   = 4'h0;
  localparam logic [CMD_W-1:0] CMD_UPDATE     = 4'h1;
  localparam logic [CMD_W-1:0] CMD_WRITE_ALL  = 4'h2;
  localparam logic [CMD_W-1:0] CMD_WRITE_UPD  = 4'h3;
  localparam logic [CMD_W-1:0] CMD_POWER      = 4'h4;
  localparam logic [CMD_W-1:0] CMD_CLEAR_SEL  = 4'h5;
  localparam logic [CMD_W-1:0] CMD_SW_RESET   = 4'h7;
  localparam logic [CMD_W-1:0] CMD_REF_SETUP  = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_ALL      = 4'hF;

  localparam logic [1:0] PD_NORMAL    = 2'h0;
  localparam logic [1:0] CLR_SEL_ZERO = 2'h0;
  localparam logic [1:0] CLR_SEL_MID  = 2'h1;
  localparam logic [1:0] CLR_SEL_FULL = 2'h2;
  localparam logic [1:0] CLR_SEL_NOP  = 2'h3;
  localparam logic [DATA_W-1:0] CLR_CODE_ZERO = 12'h000;
  localparam logic [DATA_W-1:0] CLR_CODE_MID  = 12'h800;
  localparam logic [DATA_W-1:0] CLR_CODE_FULL = 12'hFFF;
  localparam logic [DATA_W-1:0] CODE_RESET    = 12'h000;
  localparam logic              REF_RESET     = 1'b0;
  localparam logic [SYNC_W-1:0] SYNC_IDLE     = 6'h3F;

  typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_WAIT} dscd_frame_e;
endpackage : dscd_pkg

//--- dscd_sync.sv
/*
  Two-flop synchroniser for a bundle of unrelated pin levels.
  Assumes each bit is an independent slow level; no bus coherence is given.
*/
`timescale 1ns/10ps
module dscd_sync #(
  parameter int                W    = 1,
  parameter logic [W-1:0]      IDLE = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      meta_q    <= IDLE;
      syncOut_q <= IDLE;
    end
    else
    begin
      meta_q    <= pinIn;
      syncOut_q <= meta_q;
    end
  end
endmodule : dscd_sync

//--- dscd_channel.sv
/*
  One DAC channel: input register, DAC register and power mode.
  Assumes the decoder issues one-cycle strobes; clear outranks code writes, software reset outranks clear.
*/
`timescale 1ns/10ps
module dscd_channel
  import dscd_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              swReset,
  input  wire logic              writeInput,
  input  wire logic              updateDac,
  input  wire logic [DATA_W-1:0] newCode,
  input  wire logic              clearLoad,
  input  wire logic [DATA_W-1:0] clearCode,
  input  wire logic              loadLow,
  input  wire logic              modeWrite,
  input  wire logic [1:0]        modeVal,
  output logic      [DATA_W-1:0] dacCode_q,
  output logic      [1:0]        powerMode_q
);
  logic [DATA_W-1:0] inputCode_q;

  wire poweredDown  = powerMode_q != PD_NORMAL;
  wire wakeUp       = modeWrite && (modeVal == PD_NORMAL) && poweredDown;
  wire writeThrough = !poweredDown && updateDac && writeInput;
  // Held codes stay put while powered down
  wire copyInput    = !poweredDown && (loadLow || (updateDac && !writeInput));

  always_ff @(posedge core_clk)
  begin
    if (!rst_b || swReset)
    begin
      inputCode_q <= CODE_RESET;
      dacCode_q   <= CODE_RESET;
    end
    else if (clearLoad)
    begin
      inputCode_q <= clearCode;
      dacCode_q   <= clearCode;
    end
    else
    begin
      if (writeInput)
        inputCode_q <= newCode;
      if (wakeUp && loadLow)
        dacCode_q <= inputCode_q;
      else if (writeThrough)
        dacCode_q <= newCode;
      else if (copyInput)
        dacCode_q <= inputCode_q;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b || swReset)
      powerMode_q <= PD_NORMAL;
    else if (modeWrite)
      powerMode_q <= modeVal;
  end

  a_hold_while_down : assert property (@(posedge core_clk) disable iff (!rst_b)
    poweredDown && !clearLoad && !swReset && !wakeUp |=> $stable(dacCode_q))
    else $error("DAC code changed while powered down");
endmodule : dscd_channel

//--- dscd_host_model.sv
/*
  Behavioural serial master for the DAC command decoder: shifts whole or cut frames.
  Assumes the bench calls send() from one process at a time; core_clk paces all pins.
*/
`timescale 1ns/10ps
module dscd_host_model (
  input  wire logic core_clk,
  output logic      serialShiftClock,
  output logic      serialDataIn,
  output logic      frameSelectLowGroup_b,
  output logic      frameSelectHighGroup_b
);
  initial
  begin
    serialShiftClock       = 1'b1;
    serialDataIn           = 1'b0;
    frameSelectLowGroup_b  = 1'b1;
    frameSelectHighGroup_b = 1'b1;
  end

  // Clock idles high between frames; 8 core cycles per bit gives 800 ns
  task automatic send(input logic [31:0] w, input logic [1:0] grp, input int n);
    int i;
    @(posedge core_clk);
    frameSelectLowGroup_b  <= ~grp[0];
    frameSelectHighGroup_b <= ~grp[1];
    repeat (4) @(posedge core_clk);
    for (i = 31; i > 31 - n; i--)
    begin
      serialShiftClock <= 1'b1;
      serialDataIn     <= w[i];
      repeat (4) @(posedge core_clk);
      serialShiftClock <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    serialShiftClock       <= 1'b1;
    // Released data line must not keep its last value
    serialDataIn           <= ~serialDataIn;
    frameSelectLowGroup_b  <= 1'b1;
    frameSelectHighGroup_b <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask : send
endmodule : dscd_host_model

//--- dscd_top_tb.sv
/*
  Self-checking bench for dscd_top, driving the serial link through dscd_host_model.
  Assumes a 10 MHz core clock and the package's 20-cycle power-on hold.
*/
`timescale 1ns/10ps
module dscd_top_tb
  import dscd_pkg::*;
;
  logic                     core_clk, rst_b, sck, sdi, selLo_b, selHi_b, load_b, clr_b;
  logic [NUM_CH*DATA_W-1:0] dacCodeOut;
  logic [NUM_CH*2-1:0]      powerModeOut;
  logic                     refEn, refOn, clrState;
  int                       numErrors, nCompared, cycleCount;

  dscd_top dscd_top_inst (.core_clk(core_clk), .rst_b(rst_b), .serialShiftClock(sck),
    .serialDataIn(sdi), .frameSelectLowGroup_b(selLo_b), .frameSelectHighGroup_b(selHi_b),
    .loadOutputsInput_b(load_b), .asyncClearInput_b(clr_b), .dacCodeOut(dacCodeOut),
    .powerModeOut(powerModeOut), .internalReferenceEnable_q(refEn),
    .refPowerOn_q(refOn), .clearState_q(clrState));
  dscd_host_model dscd_host_model_inst (.core_clk(core_clk), .serialShiftClock(sck),
    .serialDataIn(sdi), .frameSelectLowGroup_b(selLo_b), .frameSelectHighGroup_b(selHi_b));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      numErrors++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [11:0] code(input int n);
    return dacCodeOut[n*DATA_W +: DATA_W];
  endfunction : code
  function automatic logic [11:0] mode(input int n);
    return {10'h000, powerModeOut[n*2 +: 2]};
  endfunction : mode
  // Ignored top bits are non-zero on purpose; the bottom eight come from lo
  function automatic logic [31:0] frm(input logic [3:0] c, input logic [3:0] a,
                                      input logic [11:0] d, input logic [7:0] lo);
    return {4'hA, c, a, d, lo};
  endfunction : frm
  task automatic tx(input logic [3:0] c, input logic [3:0] a, input logic [11:0] d,
                    input logic [7:0] lo, input logic [1:0] g);
    dscd_host_model_inst.send(frm(c, a, d, lo), g, 32);
  endtask : tx
  task automatic pulseClr;
    @(posedge core_clk);
    clr_b <= 1'b0;
    repeat (6) @(posedge core_clk);
    clr_b <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask : pulseClr

  task automatic tPor;
    pulseClr();
    chk(clrState, 1'b0);
    repeat (20) @(posedge core_clk);
    for (int i = 0; i < NUM_CH; i++) chk(code(i), 12'h000);
    for (int i = 0; i < NUM_CH; i++) chk(mode(i), 12'h000);
    chk(refEn, 1'b0);
    chk(refOn, 1'b0);
  endtask : tPor

  task automatic tWrite;
    tx(CMD_WRITE_IN, 4'h3, 12'h5A3, 8'hFF, 2'b01);
    chk(code(3), 12'h000);
    tx(CMD_UPDATE, 4'h3, 12'h000, 8'h00, 2'b01);
    chk(code(3), 12'h5A3);
    tx(CMD_WRITE_UPD, 4'h5, 12'hC3C, 8'h00, 2'b10);
    chk(code(13), 12'hC3C);
    chk(code(5), 12'h000);
    tx(CMD_WRITE_IN, 4'h4, 12'h111, 8'h00, 2'b01);
    tx(CMD_WRITE_ALL, 4'h2, 12'h222, 8'h00, 2'b01);
    chk(code(4), 12'h111);
    chk(code(2), 12'h222);
    tx(CMD_WRITE_UPD, ADDR_ALL, 12'h777, 8'h00, 2'b10);
    for (int i = 8; i < NUM_CH; i++) chk(code(i), 12'h777);
    tx(CMD_WRITE_UPD, 4'h9, 12'hABC, 8'h00, 2'b01);
    chk(code(1), 12'h000);
  endtask : tWrite

  task automatic tAbort;
    dscd_host_model_inst.send(frm(CMD_WRITE_UPD, 4'h0, 12'hDDD, 8'h00), 2'b01, 31);
    chk(code(0), 12'h000);
    tx(CMD_WRITE_UPD, 4'h0, 12'h0E1, 8'h00, 2'b01);
    chk(code(0), 12'h0E1);
  endtask : tAbort

  task automatic tRefPower;
    tx(CMD_REF_SETUP, 4'h0, 12'h000, 8'h01, 2'b01);
    chk(refEn, 1'b1);
    chk(refOn, 1'b1);
    for (int m = 1; m < 4; m++)
    begin
      tx(CMD_POWER, 4'h0, 12'(m), 8'hFF, 2'b11);
      for (int i = 0; i < NUM_CH; i++) chk(mode(i), 12'(m));
      chk(refOn, 1'b0);
    end
    chk(refEn, 1'b1);
    chk(code(0), 12'h0E1);
    tx(CMD_POWER, 4'h0, 12'h000, 8'hFF, 2'b10);
    chk(mode(8), 12'h000);
    chk(mode(0), 12'h003);
    chk(refOn, 1'b1);
    // Single-channel masks only once the reference is off
    tx(CMD_REF_SETUP, 4'h0, 12'h000, 8'h00, 2'b01);
    chk(refEn, 1'b0);
    tx(CMD_POWER, 4'h0, 12'h000, 8'h02, 2'b01);
    chk(mode(1), 12'h000);
    chk(mode(0), 12'h003);
    chk(refOn, 1'b0);
    tx(CMD_WRITE_IN, 4'h0, 12'h456, 8'h00, 2'b01);
    tx(CMD_POWER, 4'h0, 12'h000, 8'h01, 2'b01);
    chk(code(0), 12'h0E1);
    load_b <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk(code(0), 12'h456);
    tx(CMD_WRITE_IN, 4'h2, 12'h333, 8'h00, 2'b01);
    tx(CMD_POWER, 4'h0, 12'h000, 8'h04, 2'b01);
    chk(code(2), 12'h333);
    load_b <= 1'b1;
  endtask : tRefPower

  task automatic tClear;
    logic [11:0] exp;
    pulseClr();
    chk(code(13), CLR_CODE_ZERO);
    chk(clrState, 1'b1);
    for (int s = 0; s < 3; s++)
    begin
      tx(CMD_CLEAR_SEL, 4'h0, 12'h000, 8'(s), 2'b01);
      pulseClr();
      exp = (s == 0) ? CLR_CODE_ZERO : (s == 1) ? CLR_CODE_MID : CLR_CODE_FULL;
      for (int i = 0; i < NUM_CH; i++) chk(code(i), exp);
      tx(4'(9 + 3 * s), ADDR_ALL, 12'h5A5, 8'hFF, 2'b11);
      chk(clrState, 1'b0);
      chk(code(5), exp);
    end
    tx(CMD_CLEAR_SEL, 4'h0, 12'h000, 8'h01, 2'b01);
    fork
      dscd_host_model_inst.send(frm(CMD_WRITE_UPD, 4'h0, 12'h9AB, 8'h00), 2'b01, 32);
      begin
        repeat (100) @(posedge core_clk);
        pulseClr();
      end
    join
    chk(code(0), CLR_CODE_MID);
    chk(clrState, 1'b1);
    tx(CMD_CLEAR_SEL, 4'h0, 12'h000, 8'h03, 2'b01);
    pulseClr();
    chk(code(7), CLR_CODE_MID);
    chk(clrState, 1'b0);
  endtask : tClear

  task automatic tSwReset;
    tx(CMD_REF_SETUP, 4'h0, 12'h000, 8'h01, 2'b01);
    chk(refEn, 1'b1);
    tx(CMD_SW_RESET, 4'h0, 12'h000, 8'h00, 2'b01);
    for (int i = 0; i < NUM_CH; i++) chk(code(i), CODE_RESET);
    for (int i = 0; i < NUM_CH; i++) chk(mode(i), 12'h000);
    chk(refEn, REF_RESET);
    chk(refOn, 1'b0);
  endtask : tSwReset

  task automatic wrapUp;
    $display("errors %0d compared %0d", numErrors, nCompared);
    if (numErrors == 0 && nCompared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrapUp

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Roughly 8400 cycles expected; generous ceiling
  always @(posedge core_clk)
  begin
    cycleCount++;
    if (cycleCount == 20000)
    begin
      numErrors++;
      wrapUp();
    end
  end

  initial
  begin
    rst_b  = 1'b0;
    load_b = 1'b1;
    clr_b  = 1'b1;
    // Sync flops reset to idle-high, so two edges suffice
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    tPor();
    tWrite();
    tAbort();
    tRefPower();
    tClear();
    tSwReset();
    wrapUp();
  end
endmodule : dscd_top_tb
